// File: shared/uar_pkg.sv
// Purpose: constants and types of the asynchronous receive path
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: frame entries keep nine data bits and two error bits
// What this block does
// - frame held sets available status and flag
// - full sets status, sticky flag; shifter still free
// - single and pair destructive reads, extended variants
// - reading beyond content sets underflow flag
// - peek reads never pop nor underflow
// - flush empties buffer and shifter, not receiver
// - held off: no load, no available
// - set/clear commands; checked at frame end
// - multi-processor address frame loads despite hold-off
// - held off errors raise no flags, dropped
// - waiting unblocked frame still enters buffer later
// - overwritten waiting frame sets overflow always
// - oversample 16, 8, 6 or 4 times
// - idle falling edge starts frame, resyncs timing
// - three samples around centre, majority vote
// - 4x single sample; vote disable bit
// - high start bit aborts the frame
// - stop bits sampled like data bits
// - half stop bit never sampled
// - parity mismatch flagged, frame still loaded
// - low stop bit flagged, frame still loaded
// - errors may stop transmitter and receiver
// - new frame overwrites full shifter, overflow
package uar_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_CLKDIV = 8'h04;
    localparam logic [AW-1:0] OFS_CMD = 8'h08;
    localparam logic [AW-1:0] OFS_STATUS = 8'h0c;
    localparam logic [AW-1:0] OFS_FLAGS = 8'h10;
    localparam logic [AW-1:0] OFS_FLAGS_CLR = 8'h14;
    localparam logic [AW-1:0] OFS_READ_SINGLE = 8'h18;
    localparam logic [AW-1:0] OFS_READ_PAIR = 8'h1c;
    localparam logic [AW-1:0] OFS_READ_SINGLE_EXT = 8'h20;
    localparam logic [AW-1:0] OFS_READ_PAIR_EXT = 8'h24;
    localparam logic [AW-1:0] OFS_PEEK_SINGLE = 8'h28;
    localparam logic [AW-1:0] OFS_PEEK_PAIR = 8'h2c;
    // ----------------------------------------------------------------
    // field layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [17:0] unused;
        logic mp_mode;
        logic error_stops_receive;
        logic error_stops_transmit;
        logic [1:0] stop_len;
        logic [3:0] frame_width_field;
        logic parity_odd;
        logic parity_en;
        logic vote_disable;
        logic [1:0] oversample_select;
    } uar_ctrl_t;
    localparam uar_ctrl_t CTRL_RESET = '{frame_width_field: 4'h8,
        stop_len: 2'h1, default: '0};
    localparam int unsigned CMD_RX_EN = 0;
    localparam int unsigned CMD_RX_DIS = 1;
    localparam int unsigned CMD_HOLD_SET = 2;
    localparam int unsigned CMD_HOLD_CLR = 3;
    localparam int unsigned CMD_FLUSH = 4;
    localparam logic [1:0] STOP_HALF = 2'h0;
    localparam logic [1:0] STOP_TWO = 2'h2;
    localparam logic [1:0] OVS_4X = 2'h3;
    localparam int unsigned NFLAG = 6;
    localparam int unsigned FL_AVAIL = 0;
    localparam int unsigned FL_FULL = 1;
    localparam int unsigned FL_UNDER = 2;
    localparam int unsigned FL_OVER = 3;
    localparam int unsigned FL_PARITY_ERROR = 4;
    localparam int unsigned FL_FRAMING_ERROR = 5;
    localparam logic [15:0] CLKDIV_RESET = 16'h0000;
    localparam int unsigned ADDR_BIT = 8;
    localparam logic [1:0] DEPTH = 2'h2;
    // sample timing per oversample_select value: period, last sample
    localparam logic [4:0] OVS_PERIOD [4] = '{5'h10, 5'h08, 5'h06, 5'h04};
    localparam logic [4:0] OVS_EVAL [4] = '{5'h0a, 5'h06, 5'h05, 5'h03};
    typedef struct packed {
        logic framing_error;
        logic parity_error;
        logic [8:0] data;
    } uar_frame_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
    } uar_state_t;
endpackage : uar_pkg

// File: hw/uar_receiver.sv
// Purpose: oversampling serial receiver with two entry frame buffer
// Assumes: rx_pin asynchronous; register port on clk, read data next
// Notes: ce low freezes every flip-flop
//
// Local design decisions: the register offsets and the address-and-strobe port.
module uar_receiver
    import uar_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // serial line
    input wire logic rx_pin,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [DW-1:0] rdata,
    // status toward the rest of the transceiver
    output logic rx_frame_available,
    output logic rx_hold_off_status,
    output logic tx_stop_req
);
    // ----------------------------------------------------------------
    // registers and commands
    // ----------------------------------------------------------------
    uar_ctrl_t ctrl_q;
    logic [15:0] clkdiv_q;
    logic rx_en_q;
    logic hold_q;
    logic [NFLAG-1:0] flags_q;
    logic [NFLAG-1:0] flag_set;
    logic cmd_wr;
    logic err_stop_rx;

    assign cmd_wr = we && addr == OFS_CMD;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            clkdiv_q <= CLKDIV_RESET;
        end else if (ce && we) begin
            if (addr == OFS_CTRL) begin
                ctrl_q <= uar_ctrl_t'(wdata);
            end
            if (addr == OFS_CLKDIV) begin
                clkdiv_q <= wdata[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_en_q <= 1'b0;
        end else if (ce) begin
            if (err_stop_rx || (cmd_wr && wdata[CMD_RX_DIS])) begin
                rx_en_q <= 1'b0;
            end else if (cmd_wr && wdata[CMD_RX_EN]) begin
                rx_en_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hold_q <= 1'b0;
        end else if (ce && cmd_wr) begin
            if (wdata[CMD_HOLD_CLR]) begin
                hold_q <= 1'b0;
            end else if (wdata[CMD_HOLD_SET]) begin
                hold_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // line synchroniser and filter
    // ----------------------------------------------------------------
    logic rx_meta_q, rx_s2_q, rx_s3_q, rx_f_q, rx_prev_q;
    logic fall;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_meta_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_f_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (ce) begin
            rx_meta_q <= rx_pin;
            rx_s2_q <= rx_meta_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q) begin
                rx_f_q <= rx_s3_q;
            end
            rx_prev_q <= rx_f_q;
        end
    end

    assign fall = rx_prev_q && !rx_f_q;

    // ----------------------------------------------------------------
    // baud timing and sampling
    // ----------------------------------------------------------------
    uar_state_t state_q;
    logic [15:0] div_q;
    logic tick;
    logic start_edge;
    logic [4:0] pos_q;
    logic [1:0] smp_q;
    logic [4:0] period;
    logic [4:0] eval_pos;
    logic eval;
    logic bit_val;
    logic maj;

    assign start_edge = rx_en_q && state_q == ST_IDLE && fall;
    assign tick = div_q == clkdiv_q;
    assign period = OVS_PERIOD[ctrl_q.oversample_select];
    assign eval_pos = OVS_EVAL[ctrl_q.oversample_select];
    assign eval = tick && state_q != ST_IDLE && pos_q == eval_pos;
    assign maj = (smp_q[1] & smp_q[0]) | (smp_q[1] & rx_f_q)
        | (smp_q[0] & rx_f_q);

    always_comb begin
        if (ctrl_q.oversample_select == OVS_4X) begin
            bit_val = rx_f_q;
        end else if (ctrl_q.vote_disable) begin
            bit_val = smp_q[0];
        end else begin
            bit_val = maj;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_q <= '0;
        end else if (ce) begin
            if (start_edge || tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pos_q <= '0;
            smp_q <= 2'h3;
        end else if (ce) begin
            if (start_edge) begin
                pos_q <= 5'h01;
            end else if (tick) begin
                pos_q <= (pos_q == period - 5'h01) ? 5'h00
                    : pos_q + 5'h01;
                smp_q <= {smp_q[0], rx_f_q};
            end
        end
    end

    // ----------------------------------------------------------------
    // frame assembly
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic [8:0] asm_q;
    logic par_acc_q;
    logic parity_error_q, framing_error_q;
    logic stop2_q;
    logic done_q;
    logic last_data;

    assign last_data = bit_cnt_q == ctrl_q.frame_width_field - 4'h1;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= '0;
            asm_q <= '0;
            par_acc_q <= 1'b0;
            parity_error_q <= 1'b0;
            framing_error_q <= 1'b0;
            stop2_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (!rx_en_q) begin
                state_q <= ST_IDLE; // partial frame is discarded
            end else if (start_edge) begin
                state_q <= ST_START;
                bit_cnt_q <= '0;
                asm_q <= '0;
                par_acc_q <= 1'b0;
                parity_error_q <= 1'b0;
                framing_error_q <= 1'b0;
                stop2_q <= 1'b0;
            end else if (eval) begin
                case (state_q)
                    ST_START: begin
                        state_q <= bit_val ? ST_IDLE : ST_DATA;
                    end
                    ST_DATA: begin
                        asm_q[bit_cnt_q] <= bit_val;
                        par_acc_q <= par_acc_q ^ bit_val;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (last_data) begin
                            if (ctrl_q.parity_en) begin
                                state_q <= ST_PARITY;
                            end else if (ctrl_q.stop_len == STOP_HALF) begin
                                state_q <= ST_IDLE;
                                done_q <= 1'b1;
                            end else begin
                                state_q <= ST_STOP;
                            end
                        end
                    end
                    ST_PARITY: begin
                        parity_error_q <= par_acc_q ^ bit_val
                            ^ ctrl_q.parity_odd;
                        if (ctrl_q.stop_len == STOP_HALF) begin
                            state_q <= ST_IDLE;
                            done_q <= 1'b1;
                        end else begin
                            state_q <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (!bit_val) begin
                            framing_error_q <= 1'b1;
                        end
                        if (ctrl_q.stop_len == STOP_TWO && !stop2_q) begin
                            stop2_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // shift register and two entry buffer
    // ----------------------------------------------------------------
    uar_frame_t mem_q [2];
    uar_frame_t shift_q;
    uar_frame_t new_frame;
    logic shift_full_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic [1:0] pop_n;
    logic [1:0] pop_eff;
    logic [1:0] cnt_after;
    logic rd_ptr_after;
    logic move;
    logic blocked;
    logic accept;
    logic err_frame;
    logic flush;
    logic [1:0] count_d;

    assign new_frame = '{framing_error: framing_error_q, parity_error: parity_error_q,
        data: asm_q};
    assign flush = cmd_wr && wdata[CMD_FLUSH];
    // hold-off sampled at the completion instant only
    assign blocked = hold_q && !(ctrl_q.mp_mode && asm_q[ADDR_BIT]);
    assign accept = done_q && !blocked;
    assign err_frame = accept && (parity_error_q || framing_error_q);

    always_comb begin
        pop_n = 2'h0;
        if (re && (addr == OFS_READ_SINGLE
                || addr == OFS_READ_SINGLE_EXT)) begin
            pop_n = 2'h1;
        end else if (re && (addr == OFS_READ_PAIR
                || addr == OFS_READ_PAIR_EXT)) begin
            pop_n = 2'h2;
        end
    end

    assign pop_eff = (pop_n > count_q) ? count_q : pop_n;
    assign cnt_after = count_q - pop_eff;
    assign rd_ptr_after = rd_ptr_q ^ pop_eff[0];
    assign move = shift_full_q && cnt_after < DEPTH;
    assign count_d = flush ? 2'h0 : cnt_after + {1'b0, move};

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
            rd_ptr_q <= 1'b0;
        end else if (ce) begin
            count_q <= count_d;
            rd_ptr_q <= flush ? 1'b0 : rd_ptr_after;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && !flush && move) begin
            mem_q[rd_ptr_after ^ cnt_after[0]] <= shift_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shift_full_q <= 1'b0;
            shift_q <= '0;
        end else if (ce) begin
            if (accept) begin
                shift_q <= new_frame;
                shift_full_q <= 1'b1;
            end else if (flush || move) begin
                shift_full_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic [NFLAG-1:0] flag_clr;

    always_comb begin
        flag_set = '0;
        flag_set[FL_FULL] = count_d == DEPTH && count_q != DEPTH;
        flag_set[FL_UNDER] = pop_n > count_q;
        flag_set[FL_OVER] = done_q && shift_full_q && !move;
        flag_set[FL_PARITY_ERROR] = accept && parity_error_q;
        flag_set[FL_FRAMING_ERROR] = accept && framing_error_q;
    end

    assign flag_clr = (we && addr == OFS_FLAGS_CLR) ? wdata[NFLAG-1:0]
        : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_q <= '0;
        end else if (ce) begin
            // a set in the clearing cycle wins
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    assign err_stop_rx = err_frame && ctrl_q.error_stops_receive;

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_stop_req <= 1'b0;
        end else if (ce) begin
            tx_stop_req <= err_frame && ctrl_q.error_stops_transmit;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    uar_frame_t head, second;
    logic [DW-1:0] rd_d;
    logic [NFLAG-1:0] flags_view;

    assign head = mem_q[rd_ptr_q];
    assign second = mem_q[~rd_ptr_q];
    assign rx_frame_available = count_q != 2'h0;
    assign rx_hold_off_status = hold_q;

    always_comb begin
        flags_view = flags_q;
        flags_view[FL_AVAIL] = rx_frame_available;
        case (addr)
            OFS_CTRL: rd_d = DW'(ctrl_q);
            OFS_CLKDIV: rd_d = {16'h0000, clkdiv_q};
            OFS_STATUS: rd_d = {25'h0000000, count_q,
                state_q != ST_IDLE, hold_q, count_q == DEPTH,
                rx_frame_available, rx_en_q};
            OFS_FLAGS: rd_d = {26'h0000000, flags_view};
            OFS_READ_SINGLE: rd_d = {24'h000000, head.data[7:0]};
            OFS_READ_PAIR: rd_d = {8'h00, second.data[7:0], 8'h00,
                head.data[7:0]};
            OFS_READ_SINGLE_EXT, OFS_PEEK_SINGLE:
                rd_d = {16'h0000, head.framing_error, head.parity_error,
                    5'h00, head.data};
            OFS_READ_PAIR_EXT, OFS_PEEK_PAIR:
                rd_d = {second.framing_error, second.parity_error, 5'h00,
                    second.data, head.framing_error, head.parity_error,
                    5'h00, head.data};
            default: rd_d = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= re ? rd_d : '0;
        end
    end
endmodule : uar_receiver

// File: dv/uar_tx_model.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: bit time and stop length given in clocks per call
// Notes: line idles high between frames
module uar_tx_model (
    // clock
    input wire logic clk,
    // serial line
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    task automatic hold(input logic lv, input int n);
        line <= lv;
        repeat (n) @(posedge clk);
    endtask : hold
    // par: 0 none, 1 even bit, 2 odd bit
    task automatic send(input logic [8:0] x, input int nb, input int per,
            input int par, input logic stp, input int slen);
        logic p;
        p = (par == 2);
        @(posedge clk);
        hold(1'b0, per);
        for (int i = 0; i < nb; i++) begin
            hold(x[i], per);
            p ^= x[i];
        end
        if (par != 0) begin
            hold(p, per);
        end
        hold(stp, slen);
        // back high before any further start edge
        hold(1'b1, per);
    endtask : send
    task automatic glitch(input int n);
        @(posedge clk);
        hold(1'b0, n);
        hold(1'b1, 40);
    endtask : glitch
endmodule : uar_tx_model

// File: dv/uar_receiver_checker.sv
// Purpose: port level checks of the receive path
// Assumes: sees only the receiver's ports
// Notes: multi-processor mode tracked from control writes
module uar_receiver_checker
    import uar_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // serial line
    input wire logic rx_pin,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic we,
    input wire logic re,
    input wire logic [DW-1:0] rdata,
    // status
    input wire logic rx_frame_available,
    input wire logic rx_hold_off_status,
    input wire logic tx_stop_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic mp_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            mp_q <= 1'b0;
        end else if (ce && we && addr == OFS_CTRL) begin
            mp_q <= wdata[13];
        end
    end
    sequence s_cmd;
        ce && we && addr == OFS_CMD;
    endsequence
    // three cycles held and empty, past any frame already in flight
    sequence s_held_empty;
        (rx_hold_off_status && !rx_frame_available)[*3];
    endsequence
    chk_rdata_quiet: assert property (ce && !re |=> rdata == '0)
        else $error("read data not zero outside answer cycle");
    chk_hold_set: assert property (s_cmd ##0 wdata[CMD_HOLD_SET] &&
        !wdata[CMD_HOLD_CLR] |=> rx_hold_off_status)
        else $error("hold-off not set by command");
    chk_hold_clear: assert property (s_cmd ##0 wdata[CMD_HOLD_CLR]
        |=> !rx_hold_off_status)
        else $error("hold-off not cleared by command");
    chk_hold_steady: assert property (!(ce && we && addr == OFS_CMD)
        |=> $stable(rx_hold_off_status))
        else $error("hold-off changed without command");
    chk_reset_quiet: assert property ($fell(reset) |->
        !rx_frame_available && !rx_hold_off_status && !tx_stop_req)
        else $error("outputs not quiet after reset");
    chk_held_no_load: assert property (s_held_empty ##0 !mp_q
        |=> !rx_frame_available)
        else $error("frame loaded while held off");
    chk_peek_keeps: assert property (ce && re && rx_frame_available &&
        (addr == OFS_PEEK_SINGLE || addr == OFS_PEEK_PAIR)
        |=> rx_frame_available)
        else $error("peek removed a frame");
    chk_stop_pulse: assert property (tx_stop_req |=> !tx_stop_req)
        else $error("transmit stop request longer than one cycle");
endmodule : uar_receiver_checker
bind uar_receiver uar_receiver_checker u_chk (.clk(clk), .reset(reset),
    .ce(ce), .rx_pin(rx_pin), .addr(addr), .wdata(wdata), .we(we),
    .re(re), .rdata(rdata), .rx_frame_available(rx_frame_available),
    .rx_hold_off_status(rx_hold_off_status), .tx_stop_req(tx_stop_req));

// File: dv/testbench.sv
// Purpose: self-checking bench of the receive path
// Assumes: serial frames come from the transmitter model
// Notes: random data from a fixed seed, corner cases by hand
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    failures++; $display("wrong value %s expected %h seen %h", n, e, g); \
    end end
module testbench
    import uar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, ce, rx_line, we, re, rx_frame_available;
    logic rx_hold_off_status, tx_stop_req;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata, v;
    logic [8:0] d [4];
    int failures, tests_run, stop_cnt, div;
    uar_ctrl_t c;
    uar_receiver uut (.clk(clk), .reset(reset), .ce(ce), .rx_pin(rx_line),
        .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .rx_frame_available(rx_frame_available),
        .rx_hold_off_status(rx_hold_off_status),
        .tx_stop_req(tx_stop_req));
    uar_tx_model tx (.clk(clk), .line(rx_line));
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (tx_stop_req === 1'b1) begin
            stop_cnt++;
        end
    end
    function automatic logic [15:0] ext(logic [8:0] x, logic pe, logic fe);
        return {fe, pe, 5'h00, x};
    endfunction : ext
    function automatic int per();
        return (div + 1) * int'(OVS_PERIOD[c.oversample_select]);
    endfunction : per
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] x);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] x);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        x = rdata;
    endtask : rd
    task automatic settle();
        int i;
        for (i = 0; i < 400; i++) begin
            rd(OFS_STATUS, v);
            if (v[4] === 1'b0) break;
        end
        if (i == 400) begin
            failures++;
            tally_and_finish();
        end
        // done pulse, then one cycle into the buffer
        repeat (3) @(posedge clk);
    endtask : settle
    task automatic cfg();
        wr(OFS_CTRL, c);
        wr(OFS_CLKDIV, DW'(div));
        wr(OFS_CMD, 32'h1 << CMD_RX_EN);
        wr(OFS_FLAGS_CLR, 32'h3f);
    endtask : cfg
    task automatic frame(input logic [8:0] x, input int par, input logic s);
        int b;
        b = per();
        tx.send(x, int'(c.frame_width_field), b, par, s,
            (c.stop_len == STOP_HALF) ? b / 2 : b);
        settle();
    endtask : frame
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        addr = '0;
        wdata = '0;
        we = 1'b0;
        re = 1'b0;
        failures = 0;
        tests_run = 0;
        stop_cnt = 0;
        div = 0;
        void'($urandom(32'h7991cb7a));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_STATUS, v);
        `CHK("status", 32'h0, v)
        // every sample rate, voting on and off, random bit time
        for (int m = 0; m < 8; m++) begin
            c = CTRL_RESET;
            c.oversample_select = m[1:0];
            c.vote_disable = m[2];
            div = $urandom_range(2, 0);
            cfg();
            d[0] = 9'($urandom_range(255, 0));
            repeat ($urandom_range(9, 0)) @(posedge clk);
            frame(d[0], 0, 1'b1);
            rd(OFS_READ_SINGLE_EXT, v);
            `CHK("ovs", {16'h0, ext(d[0], 1'b0, 1'b0)}, v)
        end
        div = 0;
        c = CTRL_RESET;
        c.parity_en = 1'b1;
        c.parity_odd = 1'b1;
        cfg();
        for (int i = 0; i < 4; i++) begin
            d[i] = 9'($urandom_range(255, 0));
        end
        frame(d[0], 2, 1'b1);
        frame(d[1], 1, 1'b1);
        rd(OFS_FLAGS, v);
        `CHK("flags two", 32'h13, v)
        `CHK("avail pin", 1'b1, rx_frame_available)
        frame(d[2], 2, 1'b0);
        rd(OFS_STATUS, v);
        `CHK("status shift", 32'h47, v)
        frame(d[3], 2, 1'b1);
        rd(OFS_FLAGS, v);
        `CHK("flags over", 32'h3b, v)
        rd(OFS_PEEK_PAIR, v);
        `CHK("peek", {ext(d[1], 1'b1, 1'b0), ext(d[0], 1'b0, 1'b0)}, v)
        rd(OFS_READ_PAIR_EXT, v);
        `CHK("pair", {ext(d[1], 1'b1, 1'b0), ext(d[0], 1'b0, 1'b0)}, v)
        rd(OFS_READ_SINGLE, v);
        `CHK("shifted", {24'h0, d[3][7:0]}, v)
        wr(OFS_FLAGS_CLR, 32'h3f);
        rd(OFS_PEEK_SINGLE, v);
        rd(OFS_FLAGS, v);
        `CHK("peek empty", 32'h0, v)
        rd(OFS_READ_PAIR, v);
        rd(OFS_FLAGS, v);
        `CHK("underflow", 32'h4, v)
        // nine-bit frames, held off, multi-processor addressing
        c.frame_width_field = 4'h9;
        c.mp_mode = 1'b1;
        cfg();
        wr(OFS_CMD, 32'h1 << CMD_HOLD_SET);
        frame({1'b0, d[0][7:0]}, 1, 1'b0);
        rd(OFS_FLAGS, v);
        `CHK("held", 32'h0, v)
        `CHK("hold pin", 1'b1, rx_hold_off_status)
        frame({1'b1, d[1][7:0]}, 2, 1'b1);
        rd(OFS_READ_SINGLE_EXT, v);
        `CHK("address", {16'h0, ext({1'b1, d[1][7:0]}, 1'b0, 1'b0)}, v)
        wr(OFS_CMD, 32'h1 << CMD_HOLD_CLR);
        frame(d[2], 2, 1'b1);
        rd(OFS_READ_SINGLE_EXT, v);
        `CHK("released", {16'h0, ext(d[2], 1'b0, 1'b0)}, v)
        `CHK("hold pin off", 1'b0, rx_hold_off_status)
        // two stop bits up to the half stop case
        c = CTRL_RESET;
        c.stop_len = STOP_TWO;
        cfg();
        frame(d[0], 0, 1'b1);
        frame(d[1], 0, 1'b1);
        fork
            tx.send(d[2], 8, 16, 0, 1'b1, 16);
            begin
                repeat (60) @(posedge clk);
                wr(OFS_CMD, 32'h1 << CMD_FLUSH);
            end
        join
        settle();
        rd(OFS_STATUS, v);
        `CHK("flush count", 2'h1, v[6:5])
        rd(OFS_READ_SINGLE, v);
        `CHK("kept frame", {24'h0, d[2][7:0]}, v)
        c.error_stops_transmit = 1'b1;
        c.error_stops_receive = 1'b1;
        cfg();
        stop_cnt = 0;
        frame(d[3], 0, 1'b0);
        `CHK("stop pulses", 1, stop_cnt)
        rd(OFS_STATUS, v);
        `CHK("rx stopped", 1'b0, v[0])
        rd(OFS_READ_SINGLE_EXT, v);
        `CHK("framing", {16'h0, ext(d[3], 1'b0, 1'b1)}, v)
        c = CTRL_RESET;
        c.stop_len = STOP_HALF;
        cfg();
        tx.glitch(3);
        rd(OFS_STATUS, v);
        `CHK("false start", 32'h1, v)
        frame(d[0], 0, 1'b0);
        rd(OFS_READ_SINGLE_EXT, v);
        `CHK("half stop", {16'h0, ext(d[0], 1'b0, 1'b0)}, v)
        tally_and_finish();
    end
endmodule : testbench
